// file: atsp_regs.sv
// Purpose: Trim, timestamp marker and user pattern registers with lane output
// Assumes: Classic Wishbone slave, link clock arrives as a plain pin
// Notes:   Fuse trims load once after reset, software may overwrite them
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ns

// Contract
// - Bank1 trim applied in single-channel quadrature phase
// - Bank4 trim applied to channel B zero phase
// - Bank5 trim applied to channel B zero phase
// - Trims load from fuses, readable and writable
// - Enable bit swaps sample LSB for marker
// - Marker rides with its sample, same latency
// - Position zero puts marker on lane 0
// - Position one follows sample width LSB lane
// - Pattern sample zero holds twelve bits; the register keeps 16 bits, only the low 12 are sent
// - Pattern mode sends pattern instead of data
module atsp_regs (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [atsp_pkg::ADDR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [atsp_pkg::DATA_W-1:0]   wb_dat_i,
    output logic      [atsp_pkg::DATA_W-1:0]   wb_dat_o,
    output logic                               wb_ack_o,
    input  wire logic [7:0]                    fuse_b1_i,
    input  wire logic [7:0]                    fuse_b4_i,
    input  wire logic [7:0]                    fuse_b5_i,
    input  wire logic                          single_chan_i,
    input  wire logic [atsp_pkg::LANES-1:0]    smp_data_i,
    input  wire logic                          smp_marker_i,
    input  wire logic                          smp_valid_i,
    output logic                               smp_ready_o,
    input  wire logic                          link_clk_i,
    output logic [7:0]                         b1_trim_o,
    output logic                               b1_trim_en_o,
    output logic [7:0]                         b4_trim_o,
    output logic [7:0]                         b5_trim_o,
    output logic [atsp_pkg::LANES-1:0]         lane_data_o,
    output logic [atsp_pkg::LANES-1:0]         lane_en_o,
    output logic                               lane_valid_o
);
    import atsp_pkg::*;

    // Register storage
    logic [7:0]        b1_q;       // Bank1 quadrature trim
    logic [7:0]        b4_q;       // Bank4 zero-phase trim
    logic [7:0]        b5_q;       // Bank5 zero-phase trim
    logic [7:0]        tsc_q;      // Marker insert control
    logic [7:0]        tsl_q;      // Marker lane position
    logic [15:0]       upat_q;     // Pattern sample zero
    logic [7:0]        ctrl_q;     // Link, pattern, width
    logic              fuse_ld_q;  // Fuse copy pending
    logic              ack_q;      // Bus acknowledge

    // Link clock synchroniser and edge finder
    logic              lk_s1_q;    // First stage, read by second only
    logic              lk_s2_q;    // Second stage
    logic              lk_s3_q;    // Previous sample for edge

    // Bus decode
    wire [11:0] idx     = wb_adr_i[ADDR_W-1:2];
    wire        req     = wb_cyc_i & wb_stb_i;
    wire        wr_en   = req & wb_we_i & ack_q;
    wire        lane0   = wb_sel_i[0];
    wire        lane1   = wb_sel_i[1];
    wire        hit_b1  = (idx == IDX_B1);
    wire        hit_b4  = (idx == IDX_B4);
    wire        hit_b5  = (idx == IDX_B5);
    wire        hit_tsc = (idx == IDX_TSC);
    wire        hit_tsl = (idx == IDX_TSL);
    wire        hit_up  = (idx == IDX_USER_PATTERN_SAMPLE0);
    wire        hit_ctl = (idx == IDX_CTRL);
    wire        hit_st  = (idx == IDX_STAT);

    // Control fields
    wire        ts_en    = tsc_q[TSC_EN_BIT];
    wire        ts_pos   = tsl_q[TSL_POS_BIT];
    wire        link_en  = ctrl_q[CTRL_LINK];
    wire        test_pattern_select  = ctrl_q[CTRL_PAT];
    wire [1:0]  wid      = ctrl_q[CTRL_WID_LO +: 2];
    wire [3:0]  lsb_lane = atsp_lsb_lane(wid);
    // Marker lane: lane 0 or sample LSB lane
    wire [3:0]  mk_lane  = ts_pos ? lsb_lane : LANE_W12;

    // Buffer connections
    logic [LANES-1:0]  in_word;    // Word offered to buffer
    wire  [LANES-1:0]  bo_data;
    wire               bo_valid;
    wire               link_edge = lk_s2_q & ~lk_s3_q;
    wire               drain     = link_edge & link_en;
    wire               push      = smp_valid_i & smp_ready_o;

    // Status word shows the block's own state
    wire [7:0] stat_w = {4'h0, fuse_ld_q, bo_valid, ~smp_ready_o, lk_s2_q};

    // Read mux, unmapped addresses read as zero
    wire [31:0] rd_word =
        hit_b1  ? {24'h0, b1_q}   :
        hit_b4  ? {24'h0, b4_q}   :
        hit_b5  ? {24'h0, b5_q}   :
        hit_tsc ? {24'h0, tsc_q}  :
        hit_tsl ? {24'h0, tsl_q}  :
        hit_up  ? {16'h0, upat_q} :
        hit_ctl ? {24'h0, ctrl_q} :
        hit_st  ? {24'h0, stat_w} : 32'h0;

    // Lanes that carry live sample bits for the width
    wire [LANES-1:0] width_mask = {LANES{1'b1}} << lsb_lane;

    // Build the outgoing word from data or pattern
    always_comb begin
        in_word = test_pattern_select ? upat_q[UPAT_W-1:0] : smp_data_i;
        if (ts_en && !test_pattern_select) begin
            in_word[mk_lane] = smp_marker_i;
        end
    end

    // Bus acknowledge, one cycle after request, dropped next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q    <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            ack_q <= req & ~ack_q;
            if (req && !ack_q) begin
                wb_dat_o <= rd_word;
            end
        end
    end
    assign wb_ack_o = ack_q;

    // Fuse trims, copied once after reset then software owned
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fuse_ld_q <= 1'b1;
        end else begin
            fuse_ld_q <= 1'b0;
        end
    end

    // Trim registers; reset leaves them alone, fuse copy follows
    always_ff @(posedge clk_i) begin
        if (fuse_ld_q && !rst_i) begin
            b1_q <= fuse_b1_i;
            b4_q <= fuse_b4_i;
            b5_q <= fuse_b5_i;
        end else if (wr_en && lane0) begin
            if (hit_b1) begin
                b1_q <= wb_dat_i[7:0];
            end
            if (hit_b4) begin
                b4_q <= wb_dat_i[7:0];
            end
            if (hit_b5) begin
                b5_q <= wb_dat_i[7:0];
            end
        end
    end

    // Control registers, reserved bits kept as written
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tsc_q  <= RST_TSC;
            tsl_q  <= RST_TSL;
            ctrl_q <= RST_CTRL;
        end else if (wr_en && lane0) begin
            if (hit_tsc) begin
                tsc_q <= wb_dat_i[7:0];
            end
            if (hit_tsl) begin
                tsl_q <= wb_dat_i[7:0];
            end
            if (hit_ctl) begin
                ctrl_q <= wb_dat_i[7:0];
            end
        end
    end

    // Pattern sample, two byte lanes; writes while linked are not
    // blocked, software must park the link first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            upat_q <= RST_USER_PATTERN_SAMPLE0;
        end else if (wr_en && hit_up) begin
            if (lane0) begin
                upat_q[7:0] <= wb_dat_i[7:0];
            end
            if (lane1) begin
                upat_q[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // Trim outputs toward the sub-converter banks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            b1_trim_en_o <= 1'b0;
        end else begin
            b1_trim_en_o <= single_chan_i;
        end
        b1_trim_o <= b1_q;
        b4_trim_o <= b4_q;
        b5_trim_o <= b5_q;
    end

    // Link clock sampled by the system clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lk_s1_q <= 1'b0;
            lk_s2_q <= 1'b0;
            lk_s3_q <= 1'b0;
        end else begin
            lk_s1_q <= link_clk_i;
            lk_s2_q <= lk_s1_q;
            lk_s3_q <= lk_s2_q;
        end
    end

    // Two-entry buffer between sample source and link; a stopped
    // link fills it and stalls the source instead of losing words
    atsp_buf2 #(
        .W           (LANES)
    ) u_buf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_data_i   (in_word),
        .in_valid_i  (smp_valid_i),
        .in_ready_o  (smp_ready_o),
        .out_data_o  (bo_data),
        .out_valid_o (bo_valid),
        .out_ready_i (drain)
    );

    // Lane launch on each link clock rising edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lane_data_o  <= {LANES{1'b0}};
            lane_valid_o <= 1'b0;
        end else if (!link_en) begin
            lane_valid_o <= 1'b0;
        end else if (link_edge) begin
            lane_valid_o <= bo_valid;
            if (bo_valid) begin
                lane_data_o <= bo_data;
            end
        end
    end

    // Lane enables follow width, lane 0 kept for the marker
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lane_en_o <= {LANES{1'b0}};
        end else begin
            lane_en_o <= width_mask |
                {{(LANES-1){1'b0}}, ts_en & ~ts_pos};
        end
    end

    // Checks on the guarded logic

    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_q |=> !ack_q)
        else $error("ack held longer than one cycle");

    a_b1_trim_apply: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(single_chan_i) && !$past(rst_i) |->
            b1_trim_en_o && b1_trim_o == $past(b1_q))
        else $error("bank1 trim not applied in single channel");

    a_b4_trim_out: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_en && lane0 && hit_b4 |=> ##1 b4_trim_o == $past(wb_dat_i[7:0], 2))
        else $error("bank4 trim output does not follow write");

    a_b5_trim_out: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_en && lane0 && hit_b5 |=> ##1 b5_trim_o == $past(wb_dat_i[7:0], 2))
        else $error("bank5 trim output does not follow write");

    a_fuse_copy: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |=> b1_q == $past(fuse_b1_i) && b4_q == $past(fuse_b4_i)
            && b5_q == $past(fuse_b5_i))
        else $error("trims not loaded from fuses after reset");

    a_marker_lane: assert property (
        @(posedge clk_i) disable iff (rst_i)
        push && ts_en && !test_pattern_select && ts_pos && wid == ATSP_W8 |->
            in_word[LANE_W8] == smp_marker_i)
        else $error("marker missing from 8-bit LSB lane");

    a_lane0_kept: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ts_en && !ts_pos |=> lane_en_o[0])
        else $error("lane 0 disabled while it carries the marker");

    a_pattern_sent: assert property (
        @(posedge clk_i) disable iff (rst_i)
        push && test_pattern_select |-> in_word == upat_q[UPAT_W-1:0])
        else $error("pattern mode pushed converted data");

    a_upat_store: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_en && hit_up && wb_sel_i[1:0] == 2'h3 |=>
            upat_q == $past(wb_dat_i[15:0]))
        else $error("pattern write not stored");

    a_link_off_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !link_en |=> !lane_valid_o)
        else $error("lane valid while link disabled");

    // Position zero keeps the marker on lane 0 for every width
    a_marker_zero_lane: assert property (
        @(posedge clk_i) disable iff (rst_i)
        push && ts_en && !test_pattern_select && !ts_pos |->
            in_word[LANE_W12] == smp_marker_i)
        else $error("marker missing from lane 0");

    // With position one, eleven-bit samples carry the marker on lane 1
    a_marker_w11_lane: assert property (
        @(posedge clk_i) disable iff (rst_i)
        push && ts_en && !test_pattern_select && ts_pos && wid == ATSP_W11 |->
            in_word[LANE_W11] == smp_marker_i)
        else $error("marker missing from 11-bit LSB lane");

    // Marker off leaves converted data untouched
    a_data_untouched: assert property (
        @(posedge clk_i) disable iff (rst_i)
        push && !ts_en && !test_pattern_select |-> in_word == smp_data_i)
        else $error("sample altered with marker disabled");

    // Buffered word, marker included, leaves on the next launch
    a_lane_launch: assert property (
        @(posedge clk_i) disable iff (rst_i)
        link_en && link_edge && bo_valid |=>
            lane_valid_o && lane_data_o == $past(bo_data))
        else $error("buffered word not launched on link edge");
endmodule

// file: atsp_pkg.sv
// Purpose: Shared constants for the trim, marker and pattern register bank
// Assumes: Word-indexed register map, byte address is four times the index
// Notes:   Narrow registers sit in the low bits of the 32-bit bus word
package atsp_pkg;
    // Bus geometry
    localparam int ADDR_W = 14;
    localparam int DATA_W = 32;
    localparam int LANES  = 12;

    // Register indices, byte address is index times four
    localparam logic [11:0] IDX_B1    = 12'h113;
    localparam logic [11:0] IDX_B4    = 12'h142;
    localparam logic [11:0] IDX_B5    = 12'h152;
    localparam logic [11:0] IDX_TSC   = 12'h160;
    localparam logic [11:0] IDX_TSL   = 12'h161;
    localparam logic [11:0] IDX_USER_PATTERN_SAMPLE0 = 12'h180;
    localparam logic [11:0] IDX_CTRL  = 12'h190;
    localparam logic [11:0] IDX_STAT  = 12'h191;

    // Reset values
    localparam logic [7:0]  RST_TSC   = 8'h00;
    localparam logic [7:0]  RST_TSL   = 8'h00;
    localparam logic [15:0] RST_USER_PATTERN_SAMPLE0 = 16'h0000;
    localparam logic [7:0]  RST_CTRL  = 8'h00;

    // Field positions
    localparam int TSC_EN_BIT   = 0;
    localparam int TSL_POS_BIT  = 0;
    localparam int CTRL_LINK    = 0;
    localparam int CTRL_PAT     = 1;
    localparam int CTRL_WID_LO  = 2;
    localparam int UPAT_W       = 12;

    // Output sample width codes
    typedef enum logic [1:0] {
        ATSP_W12 = 2'b00,
        ATSP_W11 = 2'b01,
        ATSP_W8  = 2'b10
    } atsp_width_e;

    // Lane that carries the sample LSB for each width
    localparam logic [3:0] LANE_W12 = 4'h0;
    localparam logic [3:0] LANE_W11 = 4'h1;
    localparam logic [3:0] LANE_W8  = 4'h4;

    // Lowest active lane for a width code, unknown codes act as 12 bits
    function automatic logic [3:0] atsp_lsb_lane(input logic [1:0] w);
        case (w)
            ATSP_W11: atsp_lsb_lane = LANE_W11;
            ATSP_W8:  atsp_lsb_lane = LANE_W8;
            default:  atsp_lsb_lane = LANE_W12;
        endcase
    endfunction
endpackage

// file: atsp_buf2.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Both ready and valid are registered so they can drive pins
`timescale 1ns/1ns
module atsp_buf2 #(
    parameter int W = 12
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    output logic [W-1:0]      out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);
    logic [W-1:0] mem_q [2];   // Entry storage
    logic         wp_q;        // Write slot
    logic         rp_q;        // Read slot
    logic [1:0]   cnt_q;       // Occupancy
    logic [1:0]   cnt_d;       // Next occupancy
    wire          push = in_valid_i & in_ready_o;
    wire          pop  = out_valid_o & out_ready_i;

    assign out_data_o = mem_q[rp_q];
    assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

    // Storage and pointers
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wp_q] <= in_data_i;
        end
        if (rst_i) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
        end else begin
            wp_q <= wp_q ^ push;
            rp_q <= rp_q ^ pop;
        end
    end

    // Registered flags, full stalls the source
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q       <= 2'h0;
            in_ready_o  <= 1'b0;
            out_valid_o <= 1'b0;
        end else begin
            cnt_q       <= cnt_d;
            in_ready_o  <= (cnt_d != 2'h2);
            out_valid_o <= (cnt_d != 2'h0);
        end
    end
endmodule

// file: atsp_rx_model.sv
// Purpose: Receiver model on the lane side, makes the link clock
// Assumes: Lane words are captured in the system clock domain
// Notes:   Link clock stands still low while run_i is low
`timescale 1ns/1ns
module atsp_rx_model (
    input  wire logic        clk_i,
    input  wire logic        run_i,
    input  wire logic [11:0] lane_data_i,
    input  wire logic [11:0] lane_en_i,
    input  wire logic        lane_valid_i,
    output logic             link_clk_o
);
    logic [11:0] q_d[$];   // Captured lane words in arrival order
    logic [11:0] q_e[$];   // Lane enables seen with each word
    logic        lc_q = 1'b0; // Link clock one system cycle ago

    // Free phase link clock, 64 ns period, halted between bursts
    initial begin
        link_clk_o = 1'b0;
        #5;
        forever begin
            #32;
            if (run_i) begin
                link_clk_o = ~link_clk_o;
            end else begin
                link_clk_o = 1'b0;
            end
        end
    end

    // Word and marker captured together
    // Once per link period, on the falling link edge: lane valid stands
    // a whole link period, so a per-clock capture would copy each word
    always @(posedge clk_i) begin
        if (lc_q && !link_clk_o && lane_valid_i === 1'b1) begin
            q_d.push_back(lane_data_i);
            q_e.push_back(lane_en_i);
        end
        lc_q <= link_clk_o;
    end
endmodule

// file: atsp_regs_test.sv
// Purpose: Self-checking bench for the trim, marker and pattern registers
// Assumes: Wishbone classic master, receiver model on the lane side
// Notes:   Seed fixed so a failing run repeats exactly
`timescale 1ns/1ns
module atsp_regs_test;
    import atsp_pkg::*;
    logic              clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [ADDR_W-1:0] wb_adr_i;
    logic [3:0]        wb_sel_i;
    logic [DATA_W-1:0] wb_dat_i, wb_dat_o;
    logic              wb_ack_o, single_chan_i, smp_marker_i, smp_valid_i;
    logic [7:0]        fuse_b1_i, fuse_b4_i, fuse_b5_i, b1_trim_o;
    logic [7:0]        b4_trim_o, b5_trim_o;
    logic              smp_ready_o, link_clk_i, b1_trim_en_o, lane_valid_o;
    logic [LANES-1:0]  smp_data_i, lane_data_o, lane_en_o;
    logic              run;                   // Link clock enable
    logic [31:0]       rd, v;                 // Read data, random value
    logic [11:0]       d, e, sd[4];           // Popped word, enables, sent
    logic              sm[4];                 // Markers sent
    int                n_mismatch, total_checks, cyc_n;

    atsp_regs atsp_regs_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fuse_b1_i(fuse_b1_i),
        .fuse_b4_i(fuse_b4_i), .fuse_b5_i(fuse_b5_i),
        .single_chan_i(single_chan_i), .smp_data_i(smp_data_i),
        .smp_marker_i(smp_marker_i), .smp_valid_i(smp_valid_i),
        .smp_ready_o(smp_ready_o), .link_clk_i(link_clk_i),
        .b1_trim_o(b1_trim_o), .b1_trim_en_o(b1_trim_en_o),
        .b4_trim_o(b4_trim_o), .b5_trim_o(b5_trim_o),
        .lane_data_o(lane_data_o), .lane_en_o(lane_en_o),
        .lane_valid_o(lane_valid_o));
    atsp_rx_model atsp_rx_model_inst (.clk_i(clk_i), .run_i(run),
        .lane_data_i(lane_data_o), .lane_en_i(lane_en_o),
        .lane_valid_i(lane_valid_o), .link_clk_o(link_clk_i));

    // 125 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Lane holding the sample LSB when pos is set, else lane 0; spare code acts as 12 bits
    function automatic int lsb_of(input int w, input logic pos);
        if (!pos) return 0;
        return (w == 1) ? 1 : ((w == 2) ? 4 : 0);
    endfunction

    // Expected lane enables for width, marker enable and position
    function automatic logic [11:0] en_of(input int w, input logic en,
                                          input logic pos);
        return (12'hFFF << lsb_of(w, 1'b1)) | {11'h000, en & ~pos};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One classic cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [11:0] idx,
                      input logic [31:0] wd, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'hF;
        wb_dat_i <= wd;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    // Sample push, held until ready is sampled high
    task automatic push(input logic [11:0] sd_v, input logic m);
        @(posedge clk_i);
        smp_data_i   <= sd_v;
        smp_marker_i <= m;
        smp_valid_i  <= 1'b1;
        do @(posedge clk_i); while (smp_ready_o !== 1'b1);
        smp_valid_i <= 1'b0;
    endtask

    // Next word seen by the receiver
    task automatic pop(output logic [11:0] pd, output logic [11:0] pe);
        while (atsp_rx_model_inst.q_d.size() == 0) @(posedge clk_i);
        pd = atsp_rx_model_inst.q_d.pop_front();
        pe = atsp_rx_model_inst.q_e.pop_front();
    endtask

    // Hang guard, generous for well under two thousand cycles of traffic
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 40000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        n_mismatch = 0; total_checks = 0; cyc_n = 0; run = 1'b0;
        void'($urandom(92));
        rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
        wb_adr_i = '0; wb_sel_i = 4'h0; wb_dat_i = '0; single_chan_i = 1'b0;
        smp_data_i = '0; smp_marker_i = 1'b0; smp_valid_i = 1'b0;
        fuse_b1_i = 8'($urandom); fuse_b4_i = 8'($urandom);
        fuse_b5_i = 8'($urandom);
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, IDX_B1, 32'h0, rd); chk(rd, {24'h0, fuse_b1_i});
        wb(1'b0, IDX_B4, 32'h0, rd); chk(rd, {24'h0, fuse_b4_i});
        wb(1'b0, IDX_B5, 32'h0, rd); chk(rd, {24'h0, fuse_b5_i});
        wb(1'b0, IDX_TSC, 32'h0, rd); chk(rd, 32'h0);
        wb(1'b0, IDX_TSL, 32'h0, rd); chk(rd, 32'h0);
        wb(1'b0, IDX_USER_PATTERN_SAMPLE0, 32'h0, rd); chk(rd, 32'h0);
        // Random trims written, bank4 read back, all driven to the banks
        for (int k = 0; k < 4; k++) begin
            v = 32'($urandom);
            wb(1'b1, IDX_B1, v, rd);
            wb(1'b1, IDX_B4, v ^ 32'h5A, rd);
            wb(1'b1, IDX_B5, v ^ 32'hA5, rd);
            wb(1'b0, IDX_B4, 32'h0, rd); chk(rd, {24'h0, v[7:0] ^ 8'h5A});
            chk({24'h0, b1_trim_o}, {24'h0, v[7:0]});
            chk({24'h0, b4_trim_o}, {24'h0, v[7:0] ^ 8'h5A});
            chk({24'h0, b5_trim_o}, {24'h0, v[7:0] ^ 8'hA5});
            single_chan_i <= v[8];
            repeat (2) @(posedge clk_i);
            chk({31'h0, b1_trim_en_o}, {31'h0, v[8]});
            wb(1'b1, IDX_USER_PATTERN_SAMPLE0, v, rd);
            wb(1'b0, IDX_USER_PATTERN_SAMPLE0, 32'h0, rd); chk(rd, {16'h0, v[15:0]});
            wb(1'b1, IDX_TSL, v, rd);
            wb(1'b0, IDX_TSL, 32'h0, rd); chk(rd, {24'h0, v[7:0]});
        end
        wb(1'b1, 12'h1FF, 32'hFFFF_FFFF, rd);
        wb(1'b0, 12'h1FF, 32'h0, rd); chk(rd, 32'h0);
        // Every width code with marker off, on lane 0, on width LSB
        run = 1'b1;
        for (int w = 0; w < 4; w++) begin
            for (int md = 0; md < 3; md++) begin
                // Sync receiver assumed on whenever marker is
                wb(1'b1, IDX_TSC, 32'(md != 0), rd);
                wb(1'b1, IDX_TSL, 32'(md == 2), rd);
                wb(1'b1, IDX_CTRL, 32'((w << 2) | 1), rd);
                for (int k = 0; k < 4; k++) begin
                    sd[k] = 12'($urandom);
                    sm[k] = 1'($urandom);
                    push(sd[k], sm[k]);
                end
                for (int k = 0; k < 4; k++) begin
                    pop(d, e);
                    v = {20'h0, sd[k]};
                    if (md != 0) v[lsb_of(w, md == 2)] = sm[k];
                    chk({20'h0, e}, {20'h0, en_of(w, md != 0, md == 2)});
                    chk({20'h0, d & e}, v & {20'h0, e});
                end
            end
        end
        // Pattern loaded only while the link is off
        wb(1'b1, IDX_CTRL, 32'h0, rd);
        v = 32'($urandom);
        wb(1'b1, IDX_USER_PATTERN_SAMPLE0, v, rd);
        wb(1'b1, IDX_CTRL, 32'h3, rd);
        push(12'($urandom), 1'b1);
        pop(d, e); chk({20'h0, d}, {20'h0, v[11:0]});
        // Receiver stalls: two words held, ready dropped, none lost
        wb(1'b1, IDX_TSC, 32'h0, rd);
        wb(1'b1, IDX_CTRL, 32'h1, rd);
        run = 1'b0;
        repeat (20) @(posedge clk_i);
        atsp_rx_model_inst.q_d.delete();
        atsp_rx_model_inst.q_e.delete();
        for (int k = 0; k < 2; k++) begin
            sd[k] = 12'($urandom);
            push(sd[k], 1'b0);
        end
        repeat (2) @(posedge clk_i);
        chk({31'h0, smp_ready_o}, 32'h0);
        // Status: buffer holds data and is full, link pin low
        wb(1'b0, IDX_STAT, 32'h0, rd);
        chk(rd, 32'h6);
        wb(1'b0, IDX_CTRL, 32'h0, rd);
        chk(rd, 32'h1);
        run = 1'b1;
        for (int k = 0; k < 2; k++) begin
            pop(d, e); chk({20'h0, d}, {20'h0, sd[k]});
        end
        complete_run();
    end
endmodule
